// ---- rtl/drpc_pkg.sv ----
// Package of constants and types for the dual-core reset and power controller
package drpc_pkg;

  localparam int GPIO_COUNT     = 48;
  localparam int RAM_SECTIONS   = 16;
  localparam int GPIO_SEL_WIDTH = 6;

  // Reset pulse length in ns and its length in 100 MHz cycles
  localparam int CLK_PERIOD_NS    = 10;
  localparam int RST_PULSE_NS     = 100;
  localparam int RST_PULSE_CYCLES = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_WIDTH    = 8;

  // Cause codes, reported in the cause register
  localparam logic [3:0] CAUSE_NONE     = 4'h0;
  localparam logic [3:0] CAUSE_POWER_ON = 4'h1;
  localparam logic [3:0] CAUSE_PIN      = 4'h2;
  localparam logic [3:0] CAUSE_BROWNOUT = 4'h3;
  localparam logic [3:0] CAUSE_WAKE     = 4'h4;
  localparam logic [3:0] CAUSE_APP_SOFT = 4'h5;
  localparam logic [3:0] CAUSE_APP_WDOG = 4'h6;
  localparam logic [3:0] CAUSE_NET_SOFT = 4'h7;
  localparam logic [3:0] CAUSE_NET_WDOG = 4'h8;

  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_DEEP_OFF
  } drpc_power_type;

  // Reset requests from the cores
  typedef struct packed {
    logic app_soft;
    logic app_watchdog_timer;
    logic net_soft;
    logic net_watchdog_timer;
  } drpc_core_req_type;

  // Wake sources from deep off
  typedef struct packed {
    logic sensor_event;
    logic nearfield_detect;
    logic bus_supply_input;
  } drpc_wake_type;

  // Power-down configuration from the application core
  typedef struct packed {
    logic                      off_trig_en;
    logic [GPIO_SEL_WIDTH-1:0] off_trig_sel;
    logic [RAM_SECTIONS-1:0]   retain_on;
    logic [RAM_SECTIONS-1:0]   retain_off;
  } drpc_cfg_type;

  // Status to the cores and the rest of the chip
  typedef struct packed {
    logic [3:0]              cause;
    logic                    deep_off;
    logic                    abort_tasks;
    logic                    nvm_save_ok;
    logic [RAM_SECTIONS-1:0] ram_retain;
  } drpc_status_type;

endpackage : drpc_pkg

// ---- rtl/drpc_top.sv ----
// Dual-core reset sequencer, network-core hold-off and deep off control
`timescale 1ns/1ps
module drpc_top #(
  parameter int GPIO_COUNT     = drpc_pkg::GPIO_COUNT,
  parameter int RAM_SECTIONS   = drpc_pkg::RAM_SECTIONS,
  parameter int RST_PULSE_CYCLES = drpc_pkg::RST_PULSE_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  input  wire logic                        supply_good,
  input  wire logic                        brownout,
  input  wire logic                        reset_pin_n,
  input  wire drpc_pkg::drpc_core_req_type core_req,
  input  wire drpc_pkg::drpc_wake_type     wake,
  input  wire logic [GPIO_COUNT-1:0]       gpio_in,
  input  wire logic                        off_request,
  input  wire logic                        net_hold_set,
  input  wire logic                        net_release,
  input  wire drpc_pkg::drpc_cfg_type      cfg,
  output logic                             app_reset_n,
  output logic                             net_reset_n,
  output logic                             net_held_off,
  output logic                             core_power_en,
  output drpc_pkg::drpc_status_type        status
);

  localparam logic [7:0] PULSE_LEN = 8'(RST_PULSE_CYCLES);

  // Reset release through two flops, asserted without the clock
  logic rst_sync1_r;
  logic rst_sync2_r;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1_r <= 1'b0;
      rst_sync2_r <= 1'b0;
    end else begin
      rst_sync1_r <= 1'b1;
      rst_sync2_r <= rst_sync1_r;
    end
  end
  wire rst_n = rst_sync2_r;

  // Reset pin is asserted asynchronously and released through two flops
  logic pin_sync1_r;
  logic pin_sync2_r;
  wire  pin_arst_n = reset_pin_n & arst_n;
  always_ff @(posedge clock or negedge pin_arst_n) begin
    if (!pin_arst_n) begin
      pin_sync1_r <= 1'b0;
      pin_sync2_r <= 1'b0;
    end else begin
      pin_sync1_r <= 1'b1;
      pin_sync2_r <= pin_sync1_r;
    end
  end
  wire pin_low = ~pin_sync2_r;

  function automatic logic [7:0] drpc_count_down(input logic [7:0] value);
    drpc_count_down = (value != 8'h00) ? 8'(value - 8'h01) : 8'h00;
  endfunction

  drpc_pkg::drpc_power_type power_r;
  drpc_pkg::drpc_power_type power_nxt;
  logic [7:0]               app_cnt_r;
  logic [7:0]               app_cnt_nxt;
  logic [7:0]               net_cnt_r;
  logic [7:0]               net_cnt_nxt;
  logic                     hold_r;
  logic                     hold_nxt;
  logic                     por_done_r;
  logic [3:0]               cause_r;
  logic [3:0]               cause_nxt;
  logic                     pin_seen_r;
  logic                     gpio_prev_r;

  // Supply, pin and wake events that reset the whole system
  wire supply_bad  = ~supply_good | brownout;
  wire pin_release = pin_seen_r & ~pin_low;
  wire any_wake    = wake.sensor_event | wake.nearfield_detect
                   | wake.bus_supply_input;
  wire wake_exit   = (power_r == drpc_pkg::PWR_DEEP_OFF) & any_wake;

  // Selected pin, rising edge, starts deep off
  wire gpio_sel    = (cfg.off_trig_sel < GPIO_COUNT) ? gpio_in[cfg.off_trig_sel] : 1'b0;
  wire gpio_trig   = cfg.off_trig_en & gpio_sel & ~gpio_prev_r;
  wire off_enter   = (power_r == drpc_pkg::PWR_ACTIVE)
                   & (gpio_trig | off_request);

  wire app_soft    = core_req.app_soft & (power_r == drpc_pkg::PWR_ACTIVE);
  wire app_wdog    = core_req.app_watchdog_timer & (power_r == drpc_pkg::PWR_ACTIVE);
  wire net_soft    = core_req.net_soft & ~hold_r;
  wire net_wdog    = core_req.net_watchdog_timer & ~hold_r;

  wire sys_event   = supply_bad | pin_low | pin_release | wake_exit;
  wire app_event   = sys_event | app_soft | app_wdog;
  wire net_event   = app_event | net_soft | net_wdog;

  always_comb begin
    power_nxt   = power_r;
    app_cnt_nxt = drpc_count_down(app_cnt_r);
    net_cnt_nxt = drpc_count_down(net_cnt_r);
    hold_nxt    = hold_r;
    cause_nxt   = cause_r;
    if (off_enter) begin
      power_nxt = drpc_pkg::PWR_DEEP_OFF;
    end
    if (wake_exit) begin
      power_nxt = drpc_pkg::PWR_ACTIVE;
      cause_nxt = drpc_pkg::CAUSE_WAKE;
    end
    if (net_hold_set) begin
      hold_nxt = 1'b1;
    end else if (net_release) begin
      hold_nxt = 1'b0;
    end
    if (app_event) begin
      app_cnt_nxt = PULSE_LEN;
      hold_nxt    = 1'b1;
    end
    if (net_event) begin
      net_cnt_nxt = PULSE_LEN;
    end
    if (supply_bad) begin
      power_nxt = drpc_pkg::PWR_ACTIVE;
    end
    case (1'b1)
      supply_bad & ~por_done_r: cause_nxt = drpc_pkg::CAUSE_POWER_ON;
      supply_bad:               cause_nxt = drpc_pkg::CAUSE_BROWNOUT;
      pin_low:                  cause_nxt = drpc_pkg::CAUSE_PIN;
      wake_exit:                cause_nxt = drpc_pkg::CAUSE_WAKE;
      app_wdog:                 cause_nxt = drpc_pkg::CAUSE_APP_WDOG;
      app_soft:                 cause_nxt = drpc_pkg::CAUSE_APP_SOFT;
      net_wdog:                 cause_nxt = drpc_pkg::CAUSE_NET_WDOG;
      net_soft:                 cause_nxt = drpc_pkg::CAUSE_NET_SOFT;
      default:                  cause_nxt = cause_r;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      power_r     <= drpc_pkg::PWR_ACTIVE;
      app_cnt_r   <= PULSE_LEN;
      net_cnt_r   <= PULSE_LEN;
      hold_r      <= 1'b1;
      por_done_r  <= 1'b0;
      cause_r     <= drpc_pkg::CAUSE_POWER_ON;
      pin_seen_r  <= 1'b0;
      gpio_prev_r <= 1'b0;
    end else begin
      power_r     <= power_nxt;
      app_cnt_r   <= app_cnt_nxt;
      net_cnt_r   <= net_cnt_nxt;
      hold_r      <= hold_nxt;
      por_done_r  <= por_done_r | supply_good;
      cause_r     <= cause_nxt;
      pin_seen_r  <= pin_low;
      gpio_prev_r <= gpio_sel;
    end
  end

  // Core resets and power enables
  wire deep  = (power_r == drpc_pkg::PWR_DEEP_OFF);
  wire app_r = (app_cnt_r != 8'h00) | supply_bad | pin_low | deep;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      app_reset_n   <= 1'b0;
      net_reset_n   <= 1'b0;
      net_held_off  <= 1'b1;
      core_power_en <= 1'b0;
      status        <= '0;
    end else begin
      app_reset_n   <= ~app_r;
      net_reset_n   <= ~(app_r | hold_nxt | (net_cnt_r != 8'h00));
      net_held_off  <= hold_nxt;
      core_power_en <= ~deep & ~supply_bad;
      status.cause       <= cause_nxt;
      status.deep_off    <= deep;
      status.abort_tasks <= off_enter | deep | supply_bad;
      status.nvm_save_ok <= ~supply_bad & ~deep & ~off_enter;
      status.ram_retain  <= supply_bad ? '0
                          : (deep ? cfg.retain_off : cfg.retain_on);
    end
  end

endmodule // drpc_top

// ---- tb/drpc_far_side.sv ----
// Supply monitor and reset pin driver model
`timescale 1ns/1ps
module drpc_far_side (
  input  wire logic [1:0] level,
  input  wire logic       pin_low,
  output logic            supply_good,
  output logic            brownout,
  output logic            reset_pin_n
);
  // Level 2 is a good supply, 1 a sag below the brownout point
  assign supply_good = level == 2'h2;
  assign brownout    = level == 2'h1;
  assign reset_pin_n = !pin_low;
endmodule // drpc_far_side

// ---- tb/drpc_asserts.sv ----
// Port checks of the reset and power controller
`timescale 1ns/1ps
module drpc_asserts (
  input wire logic                        clock,
  input wire logic                        arst_n,
  input wire logic                        supply_good,
  input wire logic                        brownout,
  input wire logic                        reset_pin_n,
  input wire drpc_pkg::drpc_core_req_type core_req,
  input wire drpc_pkg::drpc_wake_type     wake,
  input wire logic                        off_request,
  input wire logic                        net_release,
  input wire drpc_pkg::drpc_cfg_type      cfg,
  input wire logic                        app_reset_n,
  input wire logic                        net_reset_n,
  input wire logic                        net_held_off,
  input wire logic                        core_power_en,
  input wire drpc_pkg::drpc_status_type   status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  sequence s_app_req;
    (core_req.app_soft || core_req.app_watchdog_timer) && core_power_en;
  endsequence
  sequence s_net_req;
    (core_req.net_soft || core_req.net_watchdog_timer) && app_reset_n && supply_good
      && !brownout && reset_pin_n && !off_request && !cfg.off_trig_en
      && !core_req.app_soft && !core_req.app_watchdog_timer;
  endsequence
  sequence s_off_req;
    off_request && core_power_en && wake == 3'h0;
  endsequence
  sequence s_down;
    status.deep_off && !core_power_en && !app_reset_n;
  endsequence
  // The request loads the counter on one edge; the registered reset follows on the next
  property p_app_rst;
    s_app_req |-> ##2 (!app_reset_n && net_held_off && !net_reset_n);
  endproperty
  property p_pin;
    !reset_pin_n |=> !app_reset_n;
  endproperty
  property p_brown;
    brownout |=> !app_reset_n && net_held_off && !status.nvm_save_ok;
  endproperty
  property p_net;
    s_net_req |=> app_reset_n;
  endproperty
  property p_held;
    net_held_off && !net_release |=> net_held_off;
  endproperty
  property p_held_rst;
    net_held_off |-> !net_reset_n;
  endproperty
  property p_off;
    s_off_req |-> ##[1:3] s_down;
  endproperty
  // Power state leaves deep off on one edge; the status copy follows on the next
  property p_wake;
    status.deep_off && wake != 3'h0 |-> ##2 (!status.deep_off && core_power_en);
  endproperty
  property p_abort;
    status.deep_off |-> status.abort_tasks && !status.nvm_save_ok && !core_power_en;
  endproperty
  a_app_rst: assert property (p_app_rst) else $error("app request left a core up");
  a_pin: assert property (p_pin) else $error("pin low without app reset");
  a_brown: assert property (p_brown) else $error("brownout not handled");
  a_net: assert property (p_net) else $error("net request hit app core");
  a_held: assert property (p_held) else $error("net left hold unasked");
  a_held_rst: assert property (p_held_rst) else $error("held net not in reset");
  a_off: assert property (p_off) else $error("deep off not entered");
  a_wake: assert property (p_wake) else $error("wake did not leave deep off");
  a_abort: assert property (p_abort) else $error("deep off left tasks running");
endmodule // drpc_asserts
bind drpc_top drpc_asserts u_chk (.clock, .arst_n, .supply_good, .brownout, .reset_pin_n,
  .core_req, .wake, .off_request, .net_release, .cfg, .app_reset_n, .net_reset_n,
  .net_held_off, .core_power_en, .status);

// ---- tb/tb_top.sv ----
// Self-checking bench of the reset and power controller
`timescale 1ns/1ps
module tb_top;
  logic clock = 0, arst_n = 0, off_request = 0, net_hold_set = 0, net_release = 0;
  logic pin_low = 0, supply_good, brownout, reset_pin_n;
  logic app_reset_n, net_reset_n, net_held_off, core_power_en;
  logic [1:0] level = 2'h0;
  logic [47:0] gpio_in = '0;
  drpc_pkg::drpc_core_req_type core_req = '0;
  drpc_pkg::drpc_wake_type wake = '0;
  drpc_pkg::drpc_cfg_type cfg = '{1'b0, 6'h05, 16'h00FF, 16'h0F0F};
  drpc_pkg::drpc_status_type status;
  int num_errors = 0, n_tests = 0, cnt = 0;
  drpc_far_side u_far (.level, .pin_low, .supply_good, .brownout, .reset_pin_n);
  drpc_top DUT (.clock, .arst_n, .supply_good, .brownout, .reset_pin_n, .core_req, .wake,
    .gpio_in, .off_request, .net_hold_set, .net_release, .cfg, .app_reset_n, .net_reset_n,
    .net_held_off, .core_power_en, .status);
  always #5 clock = ~clock;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("mismatches %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_release;
    net_release = 1;
    cyc(1);
    net_release = 0;
    cyc(14);
    chk(net_held_off, 0);
    chk(net_reset_n, 1);
    chk(app_reset_n, 1);
  endtask
  task automatic t_hold;
    t_release;
    net_hold_set = 1;
    net_release = 1;
    cyc(1);
    net_hold_set = 0;
    net_release = 0;
    chk(net_reset_n, 0);
    cyc(20);
    chk(net_held_off, 1);
    chk(app_reset_n, 1);
  endtask
  task automatic t_power_on;
    cyc(8);
    arst_n = 1;
    cyc(15);
    chk(app_reset_n, 0);
    chk(core_power_en, 0);
    level = 2;
    cyc(15);
    chk(app_reset_n, 1);
    chk(net_held_off, 1);
    chk(core_power_en, 1);
    chk(status.cause, drpc_pkg::CAUSE_POWER_ON);
  endtask
  task automatic t_core(input int i);
    t_release;
    core_req = 4'h8 >> i;
    cyc(1);
    core_req = '0;
    cyc(1);
    chk(app_reset_n, i >= 2);
    chk(net_reset_n, 0);
    chk(status.cause, drpc_pkg::CAUSE_APP_SOFT + 4'(i));
    cyc(14);
    chk(app_reset_n, 1);
    chk(net_held_off, i < 2);
    chk(net_reset_n, i >= 2);
  endtask
  task automatic t_pin;
    pin_low = 1;
    cyc(3);
    chk(app_reset_n, 0);
    pin_low = 0;
    cyc(16);
    chk(app_reset_n, 1);
    chk(status.cause, drpc_pkg::CAUSE_PIN);
    chk(net_held_off, 1);
  endtask
  task automatic t_brown;
    level = 1;
    cyc(2);
    chk(app_reset_n, 0);
    chk(status.nvm_save_ok, 0);
    chk(status.abort_tasks, 1);
    chk(status.ram_retain, 0);
    level = 2;
    cyc(16);
    chk(status.cause, drpc_pkg::CAUSE_BROWNOUT);
    chk(status.ram_retain, cfg.retain_on);
  endtask
  task automatic t_off(input int i);
    cfg.off_trig_en = i == 0;
    gpio_in[5] = i == 0;
    off_request = i != 0;
    cyc(1);
    off_request = 0;
    cyc(3);
    chk(status.deep_off, 1);
    chk(core_power_en, 0);
    chk(status.ram_retain, cfg.retain_off);
    chk(status.abort_tasks, 1);
    cfg.off_trig_en = 0;
    gpio_in = '0;
    wake = 3'h4 >> i;
    cyc(1);
    wake = '0;
    cyc(1);
    chk(status.deep_off, 0);
    cyc(15);
    chk(status.cause, drpc_pkg::CAUSE_WAKE);
    chk(app_reset_n, 1);
    chk(net_held_off, 1);
    chk(status.nvm_save_ok, 1);
  endtask
  always @(posedge clock) begin
    cnt <= cnt + 1;
    if (cnt == 3000) begin
      num_errors++;
      conclude;
    end
  end
  initial begin
    t_power_on;
    t_hold;
    for (int i = 0; i < 4; i++) t_core(i);
    t_pin;
    t_brown;
    for (int i = 0; i < 3; i++) t_off(i);
    conclude;
  end
endmodule // tb_top
